// File: design/usfb_frame_top.sv
// usfb_frame_top: serial transceiver with frame format, baud divisor and
// master spi mode. assumes one clock, a strobe register port with read data
// one cycle later, and a peer on the data and clock pins.
module usfb_frame_top import usfb_pkg::*; (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic [USFB_ADDR_W-1:0] reg_addr,
  input  wire logic [USFB_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [USFB_DATA_W-1:0] reg_rdata,
  output logic                        serial_out_pin,
  output logic                        serial_out_en_n,
  input  wire logic                   serial_in_pin,
  output logic                        serial_clock_pin,
  output logic                        serial_clock_oe_n
);
  typedef struct packed {
    logic [7:0]  frame;
    logic [5:0]  ctrl;
    logic [11:0] baud;
    logic [8:0]  txbuf;
    logic        txbuf_full;
    logic        txc;
    logic        tx_pend;
    logic [8:0]  rxbuf;
    logic        rx_full;
    logic        fe;
    logic        dor;
    logic        pe;
    logic [7:0]  rdata;
    logic        xck;
    logic        txd;
    usfb_tx_st_t tx_st;
    logic [3:0]  tx_idx;
    logic [8:0]  tx_sh;
    usfb_rx_st_t rx_st;
    logic [3:0]  rx_idx;
    logic [8:0]  rx_sh;
    logic        rx_par;
    logic [4:0]  spi_cnt;
    logic        rx_s1;
    logic        rx_s2;
  } usfb_state_t;

  usfb_state_t s_q;
  usfb_state_t s_d;

  logic        tick;
  logic        baud_reload;
  logic [11:0] baud_next;
  logic        spi;
  logic        par_en;
  logic        pol;
  logic [3:0]  nbits;
  logic [3:0]  tx_last;
  logic        lead;
  logic        trail;
  logic        chg;
  logic        smp;
  logic        tx_par;
  logic        rx_par_calc;
  logic        spi_in;
  logic        spi_out;
  logic [7:0]  spi_shifted;

  // mode decode shared by both directions
  assign spi    = (s_q.frame[7:6] == USFB_MODE_SPI);
  assign par_en = !spi && s_q.frame[USFB_FRM_PAR_EN];
  assign pol    = s_q.frame[USFB_FRM_POL];
  assign nbits  = usfb_data_bits({s_q.ctrl[USFB_CTL_CSZ2],
                                  s_q.frame[2:1]});
  // index of the last stop bit, index 0 being the start bit
  assign tx_last = nbits + {3'h0, par_en} + 4'h1
                   + {3'h0, s_q.frame[USFB_FRM_STOP]};

  // leading edge leaves the idle clock level, trailing edge returns to it
  assign lead  = tick && (s_q.xck == pol);
  assign trail = tick && (s_q.xck != pol);
  // framed modes change on lead and sample on trail; spi follows phase
  assign chg = spi ? (s_q.frame[USFB_FRM_PHASE] ? lead : trail)
                   : lead;
  assign smp = spi ? (s_q.frame[USFB_FRM_PHASE] ? trail : lead)
                   : trail;

  // spi shift helpers: bit order applies to both directions
  assign spi_in      = s_q.rx_s2;
  assign spi_out     = s_q.frame[USFB_FRM_ORDER] ? s_q.tx_sh[0]
                                                 : s_q.tx_sh[7];
  assign spi_shifted = s_q.frame[USFB_FRM_ORDER]
                       ? {spi_in, s_q.tx_sh[7:1]}
                       : {s_q.tx_sh[6:0], spi_in};

  // a low divisor write hands the new value straight to the prescaler
  assign baud_reload = reg_wr && (reg_addr == USFB_OFS_BAUD_L);
  assign baud_next   = baud_reload ? {s_q.baud[11:8], reg_wdata} : s_q.baud;

  usfb_baud_gen #(
    .DIV_W   (USFB_DIV_W)
  ) u_baud (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .divisor (baud_next),
    .reload  (baud_reload),
    .tick    (tick)
  );

  usfb_parity u_tx_par (
    .data  (s_q.tx_sh),
    .nbits (nbits),
    .odd   (s_q.frame[USFB_FRM_PAR_OD]),
    .par   (tx_par)
  );

  usfb_parity u_rx_par (
    .data  (s_q.rx_sh),
    .nbits (nbits),
    .odd   (s_q.frame[USFB_FRM_PAR_OD]),
    .par   (rx_par_calc)
  );

  // pins come straight from flops; enables follow the control bits
  assign reg_rdata         = s_q.rdata;
  assign serial_out_pin    = s_q.txd;
  assign serial_out_en_n   = !s_q.ctrl[USFB_CTL_TXEN];
  assign serial_clock_pin  = s_q.xck;
  assign serial_clock_oe_n = !s_q.ctrl[USFB_CTL_DIR];

  // register port first, engines after, so hardware sets win over clears
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    s_d.rx_s1 = serial_in_pin;
    s_d.rx_s2 = s_q.rx_s1;
    if (reg_wr) begin
      unique case (reg_addr)
        USFB_OFS_DATA: begin
          // writes into a full buffer are dropped
          if (!s_q.txbuf_full) begin
            s_d.txbuf      = {s_q.ctrl[USFB_CTL_TXB8], reg_wdata};
            s_d.txbuf_full = 1'b1;
          end
        end
        USFB_OFS_CTRL: begin
          s_d.ctrl = {reg_wdata[5:2], s_q.ctrl[USFB_CTL_RXB8],
                      reg_wdata[0]};
          if (!reg_wdata[USFB_CTL_RXEN]) begin
            s_d.rx_full = 1'b0;
            s_d.fe      = 1'b0;
            s_d.dor     = 1'b0;
            s_d.pe      = 1'b0;
          end
        end
        USFB_OFS_FRAME:  s_d.frame = reg_wdata;
        USFB_OFS_BAUD_L: s_d.baud[7:0] = reg_wdata;
        USFB_OFS_BAUD_H: s_d.baud[11:8] = reg_wdata[3:0];
        USFB_OFS_STATUS: begin
          if (reg_wdata[USFB_ST_TXC]) begin
            s_d.txc = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      // decode is the same in every mode except status, whose error flags read as zero in spi
      unique case (reg_addr)
        USFB_OFS_DATA: begin
          s_d.rdata   = s_q.rxbuf[7:0];
          s_d.rx_full = 1'b0;
          s_d.fe      = 1'b0;
          s_d.dor     = 1'b0;
          s_d.pe      = 1'b0;
        end
        USFB_OFS_CTRL:   s_d.rdata = {2'h0, s_q.ctrl[5:2], s_q.rxbuf[8],
                                      s_q.ctrl[USFB_CTL_TXB8]};
        USFB_OFS_FRAME:  s_d.rdata = s_q.frame;
        USFB_OFS_BAUD_L: s_d.rdata = s_q.baud[7:0];
        USFB_OFS_BAUD_H: s_d.rdata = {4'h0, s_q.baud[11:8]};
        USFB_OFS_STATUS: s_d.rdata = {s_q.rx_full, s_q.txc,
                                      !s_q.txbuf_full,
                                      s_q.fe && !spi, s_q.dor && !spi,
                                      s_q.pe && !spi, 2'h0};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // serial clock: free running in framed modes while either enable is set, bursts only in spi
    if (spi ? (s_q.tx_st == USFB_TX_BUSY)
            : (s_q.ctrl[USFB_CTL_TXEN] || s_q.ctrl[USFB_CTL_RXEN])) begin
      if (tick) begin
        s_d.xck = !s_q.xck;
      end
    end else begin
      s_d.xck = pol;
    end

    if (spi) begin
      // one controller runs both directions off the shared shifter
      if (s_q.tx_st == USFB_TX_IDLE) begin
        if (s_q.txbuf_full && s_q.ctrl[USFB_CTL_TXEN]) begin
          s_d.tx_sh      = {1'b0, s_q.txbuf[7:0]};
          s_d.txbuf_full = 1'b0;
          s_d.tx_st      = USFB_TX_BUSY;
          s_d.spi_cnt    = 5'h00;
          if (!s_q.frame[USFB_FRM_PHASE]) begin
            s_d.txd = s_q.frame[USFB_FRM_ORDER] ? s_q.txbuf[0]
                                                : s_q.txbuf[7];
          end
        end
      end else if (tick) begin
        s_d.spi_cnt = s_q.spi_cnt + 5'h01;
        if (smp) begin
          s_d.tx_sh[7:0] = spi_shifted;
        end
        if (chg) begin
          s_d.txd = spi_out;
        end
        if (s_q.spi_cnt == USFB_SPI_EDGES) begin
          s_d.tx_st = USFB_TX_IDLE;
          s_d.txc   = 1'b1;
          if (s_q.ctrl[USFB_CTL_RXEN]) begin
            if (s_q.rx_full && !(reg_rd && reg_addr == USFB_OFS_DATA)) begin
              s_d.dor = 1'b1;
            end else begin
              s_d.rxbuf   = {1'b0, s_d.tx_sh[7:0]};
              s_d.rx_full = 1'b1;
            end
          end
        end
      end
    end else begin
      // framed transmitter: start, data lsb first, parity, stops
      if (chg && s_q.ctrl[USFB_CTL_TXEN]) begin
        if (s_q.tx_st == USFB_TX_IDLE) begin
          if (s_q.txbuf_full) begin
            s_d.txd        = 1'b0;
            s_d.tx_sh      = s_q.txbuf;
            s_d.txbuf_full = 1'b0;
            s_d.tx_idx     = 4'h1;
            s_d.tx_st      = USFB_TX_BUSY;
          end else begin
            s_d.txd = 1'b1;
            if (s_q.tx_pend) begin
              s_d.txc     = 1'b1;
              s_d.tx_pend = 1'b0;
            end
          end
        end else begin
          s_d.tx_idx = s_q.tx_idx + 4'h1;
          if (s_q.tx_idx <= nbits) begin
            s_d.txd = s_q.tx_sh[4'(s_q.tx_idx - 4'h1)];
          end else if (par_en && s_q.tx_idx == nbits + 4'h1) begin
            s_d.txd = tx_par;
          end else begin
            s_d.txd = 1'b1;
          end
          if (s_q.tx_idx == tx_last) begin
            s_d.tx_st   = USFB_TX_IDLE;
            s_d.tx_pend = 1'b1;
          end
        end
      end
      // framed receiver checks only the first stop bit
      if (smp && s_q.ctrl[USFB_CTL_RXEN]) begin
        if (s_q.rx_st == USFB_RX_IDLE) begin
          if (!s_q.rx_s2) begin
            s_d.rx_st  = USFB_RX_BUSY;
            s_d.rx_idx = 4'h0;
            s_d.rx_sh  = 9'h000;
          end
        end else begin
          s_d.rx_idx = s_q.rx_idx + 4'h1;
          if (s_q.rx_idx < nbits) begin
            s_d.rx_sh[s_q.rx_idx] = s_q.rx_s2;
          end else if (par_en && s_q.rx_idx == nbits) begin
            s_d.rx_par = s_q.rx_s2;
          end else begin
            s_d.rx_st = USFB_RX_IDLE;
            if (s_d.rx_full) begin
              s_d.dor = 1'b1;
            end else begin
              s_d.rxbuf   = s_q.rx_sh;
              s_d.rx_full = 1'b1;
              s_d.fe      = !s_q.rx_s2;
              s_d.pe      = par_en && (s_q.rx_par != rx_par_calc);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.frame <= USFB_FRAME_RST;
      s_q.txd   <= 1'b1;
      s_q.rx_s1 <= 1'b1;
      s_q.rx_s2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  a_spi_flags_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_n) (reg_rd && reg_addr == USFB_OFS_STATUS && spi)
    |=> (reg_rdata[4:2] == 3'h0))
    else $error("error flags visible in spi mode");
  // the read must return the stored nibble with the reserved bits as zero
  a_baud_high_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n) (reg_rd && reg_addr == USFB_OFS_BAUD_H)
    |=> (reg_rdata == {4'h0, $past(s_q.baud[11:8])}))
    else $error("divisor high read wrong");
  a_data_write_start: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (reg_wr && reg_addr == USFB_OFS_DATA && !s_q.txbuf_full)
    |=> s_q.txbuf_full)
    else $error("data write not taken");
  // idle level follows the polarity seen one cycle earlier, so a frame
  // write that flips polarity lands one cycle later
  a_spi_clock_idle: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (spi && s_q.tx_st == USFB_TX_IDLE) |=> (s_q.xck == $past(pol)))
    else $error("spi clock not at idle level");
  a_tx_stop_high: assert property (@(posedge ref_clk)
    disable iff (!rst_n) $rose(s_q.tx_pend) |-> s_q.txd)
    else $error("stop bit not high");
  a_clock_toggle: assert property (@(posedge ref_clk)
    disable iff (!rst_n) (tick && !spi && s_q.ctrl[USFB_CTL_TXEN])
    |=> (s_q.xck != $past(s_q.xck)))
    else $error("serial clock did not toggle on expiry");
  a_pe_needs_par: assert property (@(posedge ref_clk)
    disable iff (!rst_n) $rose(s_q.pe) |-> $past(par_en))
    else $error("parity error without parity enabled");

  c_spi_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    spi && $fell(s_q.tx_st == USFB_TX_BUSY));
  c_parity_err: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_q.pe));
  c_rx_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !spi && $rose(s_q.rx_full));
endmodule // usfb_frame_top

// File: design/usfb_pkg.sv
// usfb_pkg: constants, offsets and field layout of the serial frame block.
// assumes an 8-bit register port and a single system clock.
package usfb_pkg;
  localparam int          USFB_ADDR_W     = 3;
  localparam int          USFB_DATA_W     = 8;
  localparam int          USFB_DIV_W      = 12;
  // register offsets
  localparam logic [2:0]  USFB_OFS_DATA   = 3'h0;
  localparam logic [2:0]  USFB_OFS_CTRL   = 3'h1;
  localparam logic [2:0]  USFB_OFS_FRAME  = 3'h2;
  localparam logic [2:0]  USFB_OFS_BAUD_L = 3'h3;
  localparam logic [2:0]  USFB_OFS_BAUD_H = 3'h4;
  localparam logic [2:0]  USFB_OFS_STATUS = 3'h5;
  // frame_control fields
  localparam int          USFB_FRM_PAR_EN = 5;
  localparam int          USFB_FRM_PAR_OD = 4;
  localparam int          USFB_FRM_STOP   = 3;
  localparam int          USFB_FRM_ORDER  = 2;  // bit_order_sel in spi mode
  localparam int          USFB_FRM_PHASE  = 1;  // clock_phase_sel in spi mode
  localparam int          USFB_FRM_POL    = 0;
  localparam logic [7:0]  USFB_FRAME_RST  = 8'h06;
  // control register fields
  localparam int          USFB_CTL_DIR    = 5;  // clock_pin_direction
  localparam int          USFB_CTL_RXEN   = 4;
  localparam int          USFB_CTL_TXEN   = 3;
  localparam int          USFB_CTL_CSZ2   = 2;
  localparam int          USFB_CTL_RXB8   = 1;
  localparam int          USFB_CTL_TXB8   = 0;
  // status register fields
  localparam int          USFB_ST_RXC     = 7;
  localparam int          USFB_ST_TXC     = 6;
  localparam int          USFB_ST_DRE     = 5;
  localparam int          USFB_ST_FE      = 4;
  localparam int          USFB_ST_DOR     = 3;
  localparam int          USFB_ST_PE      = 2;
  // operating modes
  localparam logic [1:0]  USFB_MODE_ASYNC = 2'h0;
  localparam logic [1:0]  USFB_MODE_SYNC  = 2'h1;
  localparam logic [1:0]  USFB_MODE_SPI   = 2'h3;
  localparam logic [4:0]  USFB_SPI_EDGES  = 5'h0f; // last of 16 clock edges

  typedef enum logic {USFB_TX_IDLE, USFB_TX_BUSY} usfb_tx_st_t;
  typedef enum logic {USFB_RX_IDLE, USFB_RX_BUSY} usfb_rx_st_t;

  // character size code to data bit count; reserved codes fall back to 8
  function automatic logic [3:0] usfb_data_bits(input logic [2:0] code);
    unique case (code)
      3'h0:    usfb_data_bits = 4'h5;
      3'h1:    usfb_data_bits = 4'h6;
      3'h2:    usfb_data_bits = 4'h7;
      3'h7:    usfb_data_bits = 4'h9;
      default: usfb_data_bits = 4'h8;
    endcase
  endfunction
endpackage

// File: design/usfb_baud_gen.sv
// usfb_baud_gen: 12-bit down-counting prescaler giving one tick per expiry.
// assumes reload is a one-cycle pulse from the register port.
module usfb_baud_gen import usfb_pkg::*; #(
  parameter int DIV_W = USFB_DIV_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             reload,
  output logic                  tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } usfb_bg_t;

  usfb_bg_t s_q;
  usfb_bg_t s_d;

  // a reload suppresses the tick so the new period starts cleanly
  assign tick = (s_q.cnt == '0) && !reload;

  // count down, reload on expiry or on a low divisor write
  always_comb begin
    s_d = s_q;
    if (reload) begin
      s_d.cnt = divisor;
    end else if (s_q.cnt == '0) begin
      s_d.cnt = divisor;
    end else begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_reload_count: assert property (@(posedge ref_clk)
    disable iff (!rst_n) reload |=> (s_q.cnt == $past(divisor)))
    else $error("prescaler not reloaded by low divisor write");
  a_tick_spacing: assert property (@(posedge ref_clk)
    disable iff (!rst_n) (tick && divisor != '0 && !reload) |=> !tick)
    else $error("ticks closer than divisor plus one");
endmodule // usfb_baud_gen

// File: design/usfb_parity.sv
// usfb_parity: parity over the active data bits of a character.
// assumes unused upper data bits may hold anything; they are masked here.
module usfb_parity import usfb_pkg::*; (
  input  wire logic [8:0] data,
  input  wire logic [3:0] nbits,
  input  wire logic       odd,
  output logic            par
);
  logic [8:0] mask;

  // even parity makes the total count of ones even, odd inverts it
  always_comb begin
    mask = 9'h000;
    for (int i = 0; i < 9; i++) begin
      mask[i] = (4'(i) < nbits);
    end
    par = (^(data & mask)) ^ odd;
  end
endmodule // usfb_parity

// File: sim/usfb_peer.sv
// usfb_peer: behavioural spi slave on the far side of the serial pins.
// assumes the bench picks the mode and arms one byte per transfer.
module usfb_peer (
  input  wire logic  rst_n,
  input  wire logic  sck,
  input  wire logic  mosi,
  input  wire logic  cpol,
  input  wire logic  cpha,
  input  wire logic  lsb_first,
  input  wire logic  spi_on,
  output logic       miso,
  output logic [7:0] rx_byte,
  output int         n_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_byte = 8'h00;
  int         idx     = 0;
  // bit i of the armed byte; past the end the line toggles, never holds
  function automatic logic nxt(input int i);
    if (i > 7)
      return !miso;
    return lsb_first ? tx_byte[i] : tx_byte[7-i];
  endfunction
  // arm a transfer; in phase 0 the first bit must stand before any edge
  task automatic load(input logic [7:0] b);
    tx_byte = b;
    idx = 0;
    n_edges = 0;
    rx_byte = 8'h00;
    if (!cpha)
      miso = nxt(0);
  endtask
  // framed traffic has no spi edges, so the bench sets the line itself
  task automatic put_bit(input logic b);
    miso <= b;
  endtask
  initial miso = 1'b1;
  // leading edge leaves the idle level; set-up and sample edges alternate
  always @(sck) begin
    if (rst_n === 1'b1 && spi_on) begin
      n_edges++;
      if ((sck !== cpol) == cpha) begin
        miso = nxt(idx);
      end else begin
        rx_byte = lsb_first ? {mosi, rx_byte[7:1]}
                            : {rx_byte[6:0], mosi};
        idx++;
        if (idx > 7 && cpha)
          miso = !miso;
      end
    end
  end
endmodule // usfb_peer

// File: sim/test_usfb_frame_top.sv
// test_usfb_frame_top: register-level tests of frame format, baud divisor
// and spi master mode. assumes usfb_peer answers on the serial pins.
module test_usfb_frame_top import usfb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk    = 1'b0;
  logic                   rst_n      = 1'b0;
  logic [USFB_ADDR_W-1:0] reg_addr   = 3'h0;
  logic [USFB_DATA_W-1:0] reg_wdata  = 8'h00;
  logic                   reg_wr     = 1'b0;
  logic                   reg_rd     = 1'b0;
  logic [USFB_DATA_W-1:0] reg_rdata;
  logic                   so, so_en_n, sck, sck_oe_n, si;
  logic                   cpol = 1'b0, cpha = 1'b0, lsbf = 1'b0;
  logic                   spi_on     = 1'b0;
  logic [7:0]             prx;
  int                     pe;
  int                     n_mismatch = 0;
  int                     n_checks   = 0;
  logic [2:0]             csz [5]    = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  // design and far-side model
  usfb_frame_top u_usfb_frame_top (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .serial_out_pin(so),
    .serial_out_en_n(so_en_n), .serial_in_pin(si), .serial_clock_pin(sck),
    .serial_clock_oe_n(sck_oe_n));
  usfb_peer u_usfb_peer (.rst_n, .sck, .mosi(so), .cpol, .cpha,
    .lsb_first(lsbf), .spi_on, .miso(si), .rx_byte(prx), .n_edges(pe));
  // 50 MHz system clock
  always #10 ref_clk = ~ref_clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    n_mismatch++;
    $display("wrong value at %0t: %s never came", $time, what);
    conclude();
  endtask
  // strobes are lowered and a cycle passes, so calls never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp,
                       input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask
  // next leading (lead=1) or trailing serial clock edge, bounded
  task automatic edge_wait(input logic lead);
    logic p;
    for (int i = 0; i < 4000; i++) begin
      p = sck;
      @(posedge ref_clk);
      #1;
      if (sck !== p && (sck !== cpol) == lead)
        return;
    end
    hang("serial clock edge");
  endtask
  // poll tx complete, then clear it by writing one
  task automatic wait_txc();
    logic [7:0] s;
    for (int i = 0; i < 3000; i++) begin
      rd(USFB_OFS_STATUS, s);
      if (s[USFB_ST_TXC] === 1'b1) begin
        wr(USFB_OFS_STATUS, 8'h40);
        return;
      end
    end
    hang("tx complete");
  endtask
  initial begin
    logic [7:0]  v;
    logic [8:0]  dat;
    logic [12:0] fr;
    logic [1:0]  p;
    time         t0;
    int          n, len, j;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    // reset values, reserved divisor bits and unmapped places
    rdchk(USFB_OFS_FRAME, 8'h06, "frame reset");
    rdchk(USFB_OFS_BAUD_L, 8'h00, "low reset");
    rdchk(USFB_OFS_BAUD_H, 8'h00, "high reset");
    rdchk(USFB_OFS_STATUS, 8'h20, "status reset");
    wr(3'h7, 8'hff);
    rdchk(3'h7, 8'h00, "unmapped place");
    wr(USFB_OFS_BAUD_H, 8'hff); // reserved bits set on purpose
    rdchk(USFB_OFS_BAUD_H, 8'h0f, "high reserved");
    wr(USFB_OFS_BAUD_H, 8'h00);
    wr(USFB_OFS_BAUD_L, 8'h03);
    rdchk(USFB_OFS_BAUD_L, 8'h03, "low divisor");
    chk(sck_oe_n, 1'b1, "clock pin idle");
    $display("test registers done");
    // every spi mode in both orders; parity code 11 must stay inert
    spi_on = 1'b1;
    wr(USFB_OFS_FRAME, 8'hc0);
    wr(USFB_OFS_CTRL, 8'h38); // clock pin direction with enables
    chk(sck_oe_n, 1'b0, "clock pin driven");
    chk(so_en_n, 1'b0, "data pin driven");
    for (int m = 0; m < 8; m++) begin
      {lsbf, cpol, cpha} = m[2:0];
      wr(USFB_OFS_FRAME, {4'hf, 1'b0, lsbf, cpha, cpol});
      // arm only once the clock has settled at its new idle level, so a
      // polarity change is not counted as a transfer edge
      repeat (2) @(posedge ref_clk);
      chk(sck, cpol, "spi clock idle");
      u_usfb_peer.load(8'h5c ^ m[7:0]);
      wr(USFB_OFS_DATA, 8'ha3 + m[7:0]);
      wait_txc();
      chk(9'(pe), 9'h010, "clock edges");
      chk(prx, 8'ha3 + m[7:0], "peer byte");
      rd(USFB_OFS_STATUS, v);
      chk({v[7], v[4:2]}, 4'h8, "spi flags");
      rdchk(USFB_OFS_DATA, 8'h5c ^ m[7:0], "spi rx byte");
    end
    $display("test spi modes done");
    // half period of the serial clock for divisors 0 and 0x105
    {lsbf, cpol, cpha} = 3'h0;
    wr(USFB_OFS_FRAME, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      wr(USFB_OFS_BAUD_H, k ? 8'h01 : 8'h00); // idle between
      wr(USFB_OFS_BAUD_L, k ? 8'h05 : 8'h00);
      u_usfb_peer.load(8'h00);
      wr(USFB_OFS_DATA, 8'h96);
      edge_wait(1'b1);
      edge_wait(1'b0);
      t0 = $time;
      edge_wait(1'b1);
      chk(9'(($time - t0) / 20), k ? 9'h106 : 9'h001,
          "half period");
      wait_txc();
      chk(prx, 8'h96, "peer byte");
      rd(USFB_OFS_DATA, v);
    end
    $display("test bit rate done");
    // framed synchronous send: sizes, parity codes, stops, polarity
    spi_on = 1'b0;
    u_usfb_peer.put_bit(1'b1);
    wr(USFB_OFS_BAUD_H, 8'h00);
    wr(USFB_OFS_BAUD_L, 8'h03);
    for (int i = 0; i < 5; i++) begin
      p = i[1:0];
      cpol = (i > 2);
      dat = 9'h1b5 ^ 9'(i);
      n = (csz[i] == 3'h7) ? 9 : 5 + csz[i];
      fr = 13'(dat & (9'h1ff >> (9 - n)));
      len = n;
      if (p[1]) begin
        fr[len] = ^fr ^ p[0];
        len++;
      end
      fr[len] = 1'b1;
      fr[len + 1] = i[0]; // second stop, else the next start bit
      len = len + 2 + i[0];
      wr(USFB_OFS_FRAME, {2'b01, p, i[0], csz[i][1:0], cpol});
      wr(USFB_OFS_CTRL, {5'h07, csz[i][2], 1'b0, dat[8]});
      wr(USFB_OFS_DATA, dat[7:0]);
      j = 0;
      do begin
        edge_wait(1'b0);
        j++;
      end while (so !== 1'b0 && j < 40);
      if (so !== 1'b0)
        hang("start bit");
      wr(USFB_OFS_DATA, dat[7:0]); // refill so frames run back to back
      for (j = 0; j < len; j++) begin
        edge_wait(1'b0);
        chk(so, fr[j], "frame bit");
      end
      wait_txc();
    end
    $display("test framed send done");
    // framed receive with good and corrupted even parity, two stops set
    cpol = 1'b0;
    wr(USFB_OFS_FRAME, 8'h6e);
    wr(USFB_OFS_CTRL, 8'h20); // receiver off flushes leftovers
    wr(USFB_OFS_CTRL, 8'h30);
    for (int e = 0; e < 2; e++) begin
      fr = {2'b11, ^8'h3d ^ e[0], 8'h3d, 1'b0};
      for (j = 0; j < 12; j++) begin
        edge_wait(1'b1);
        u_usfb_peer.put_bit(fr[j]);
      end
      edge_wait(1'b1);
      rd(USFB_OFS_STATUS, v);
      chk({v[7], v[4:2]}, {1'b1, 2'b00, e[0]}, "rx flags");
      rdchk(USFB_OFS_DATA, 8'h3d, "rx byte");
    end
    $display("test framed receive done");
    conclude();
  end
endmodule // test_usfb_frame_top
